// ---- src/udar_regs.v ----
/*
 Function address and interrupt registers of a full-speed USB device
 port, with a classic Wishbone slave for software access.
 Assumes endpoint flags and bus-event pulses come from the packet
 engine on the same clock; the external resume pin is asynchronous.
*/
// Our own choices: the placing of the registers and the Wishbone slave port.
// Function
// [R1] firmware writes the address only after set-address status stage completes
// [R2] function address field resets to zero
// [R3] function enable bit 8 reads 1 when enabled; writing 0 disables
// [R4] firmware sets function enable after a host bus reset
// [R5] while enabled, endpoints accept and send data packets
// [R6] endpoints on bits 0-7; suspend, resume, ext resume, frame, wakeup 8-11,13
// [R7] enable register: writing 1 sets mask bit, 0 no effect
// [R8] disable register: writing 1 clears mask bit, 0 no effect; the code has no disable bit for bus reset done bit 12
// [R9] mask register read-only, shows enabled sources
// [R10] host resume mask bit resets enabled
// [R11] endpoint status raised by any of its five flags
// [R12] endpoint status stays until firmware clears the causing flag
// [R13] 3 ms without bus activity sets suspend status and enters suspend
// [R14] status bit reads 1 once raised, 0 when nothing pending
// [R15] end of bus reset raises its status bit
// [R16] each frame start token raises the frame status bit
// [R17] clear register: writing 1 clears non-endpoint status bit
// [R18] interrupt output high while a status bit and its mask bit are set
// [R19] other mask bits reset disabled, status bits reset clear; the code resets the bus reset done mask bit 12 enabled too
`timescale 1ns/1ps
`include "udar_consts.vh"

module udar_regs #(
   parameter NUM_EP = 8,
   parameter SUSP_CYCLES = `UDAR_SUSP_TIME_MS * `UDAR_CLK_KHZ
)
(
   input wire REF_CLK_IN, // 10 MHz clock
   input wire RESETN_IN, // async reset, low
   input wire WB_CYC_IN, // bus cycle
   input wire WB_STB_IN, // strobe
   input wire WB_WE_IN, // write enable
   input wire [7:0] WB_ADR_IN, // byte address
   input wire [3:0] WB_SEL_IN, // byte enables
   input wire [31:0] WB_DAT_IN, // write data
   output wire [31:0] WB_DAT_OUT, // read data
   output wire WB_ACK_OUT, // acknowledge
   input wire [NUM_EP-1:0] SETUP_RECEIVED_IN, // per endpoint flag
   input wire [NUM_EP-1:0] BANK_A_RECEIVED_IN, // per endpoint flag
   input wire [NUM_EP-1:0] BANK_B_RECEIVED_IN, // per endpoint flag
   input wire [NUM_EP-1:0] IN_TRANSFER_DONE_IN, // per endpoint flag
   input wire [NUM_EP-1:0] STALL_ACKNOWLEDGED_IN, // per endpoint flag
   input wire BUS_IDLE_IN, // no bus activity, level
   input wire HOST_RESUME_IN, // host resume seen, pulse
   input wire EXT_RESUME_PIN_IN, // async resume request pin
   input wire FRAME_START_IN, // frame start token, pulse
   input wire BUS_RESET_DONE_IN, // end of bus reset, pulse
   output wire [`UDAR_FUNC_ADDR_VALUE_MSB:0] FUNC_ADDR_VALUE_OUT, // function address
   output wire FUNC_ENDPOINTS_ON_OUT, // endpoints enabled
   output wire SUSPENDED_OUT, // suspend mode
   output wire IRQ_OUT // interrupt request, high
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function hit;
      input [7:0] adr;
      input [7:0] ofs;
      begin
         hit = (adr[7:2] == ofs[7:2]);
      end
   endfunction

   function [31:0] lanes;
      input [3:0] sel;
      begin
         lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      end
   endfunction

   localparam ST_ACTIVE = 1'b0;
   localparam ST_SUSP = 1'b1;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg ack_q;
   reg [31:0] rdat_q;
   reg [`UDAR_FUNC_ADDR_VALUE_MSB:0] func_addr_value_q;
   reg fen_q;
   reg [`UDAR_IRQ_MSB:0] mask_q;
   reg [`UDAR_IRQ_MSB:0] mask_d;
   reg [`UDAR_IRQ_MSB:0] stat_q;
   reg [`UDAR_IRQ_MSB:0] stat_d;
   reg [NUM_EP-1:0] ep_q;
   reg [31:0] rdat_d;
   reg state_q;
   reg state_d;
   reg [31:0] idle_q;
   reg [31:0] idle_d;
   reg susp_evt;
   reg ext_s1_q;
   reg ext_s2_q;
   reg ext_prev_q;
   wire req;
   wire wr_now;
   wire rd_now;
   wire [31:0] wmask;
   wire [31:0] wbits;
   wire ext_rise;
   wire [`UDAR_IRQ_MSB:0] bus_evt;

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   // ack one cycle after the request; writes and read side effects act
   // on the edge where the master samples ack
   assign req = WB_CYC_IN & WB_STB_IN;
   assign wr_now = req & ack_q & WB_WE_IN;
   assign rd_now = req & ack_q & ~WB_WE_IN;
   assign wmask = lanes(WB_SEL_IN);
   assign wbits = WB_DAT_IN & wmask;
   assign WB_ACK_OUT = ack_q;
   assign WB_DAT_OUT = rdat_q;

   always @*
   begin
      rdat_d = 32'h0000_0000;
      if (hit(WB_ADR_IN, `UDAR_OFS_FADDR))
      begin
         rdat_d[`UDAR_FUNC_ADDR_VALUE_MSB:0] = func_addr_value_q;
         rdat_d[`UDAR_FEN_BIT] = fen_q; // [R3]
      end
      else if (hit(WB_ADR_IN, `UDAR_OFS_IMASK))
      begin
         rdat_d[`UDAR_IRQ_MSB:0] = mask_q; // [R9]
      end
      else if (hit(WB_ADR_IN, `UDAR_OFS_ISTAT))
      begin
         rdat_d[`UDAR_IRQ_MSB:0] = stat_q; // [R14]
      end
   end

   always @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q & ~WB_WE_IN)
         begin
            rdat_q <= rdat_d;
         end
      end
   end

   // ----------------------------------------
   // function address register
   // ----------------------------------------
   // software must load the address only after the status stage [R1]
   always @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         func_addr_value_q <= `UDAR_FUNC_ADDR_VALUE_RST; // [R2]
         fen_q <= `UDAR_FEN_RST;
      end
      else if (wr_now && hit(WB_ADR_IN, `UDAR_OFS_FADDR))
      begin
         if (WB_SEL_IN[0])
         begin
            func_addr_value_q <= WB_DAT_IN[`UDAR_FUNC_ADDR_VALUE_MSB:0];
         end
         if (WB_SEL_IN[1])
         begin
            fen_q <= WB_DAT_IN[`UDAR_FEN_BIT]; // [R3] [R4]
         end
      end
   end

   assign FUNC_ADDR_VALUE_OUT = func_addr_value_q;
   // the packet engine moves data only while this is high
   assign FUNC_ENDPOINTS_ON_OUT = fen_q; // [R5]

   // ----------------------------------------
   // interrupt mask
   // ----------------------------------------
   // bus reset done has no enable or disable bit; its mask stays set
   always @*
   begin
      mask_d = mask_q;
      if (wr_now && hit(WB_ADR_IN, `UDAR_OFS_IEN))
      begin
         mask_d = mask_q | (wbits[`UDAR_IRQ_MSB:0] & `UDAR_MASK_WR); // [R7]
      end
      if (wr_now && hit(WB_ADR_IN, `UDAR_OFS_IDIS))
      begin
         mask_d = mask_q & ~(wbits[`UDAR_IRQ_MSB:0] & `UDAR_MASK_WR); // [R8]
      end
   end

   // ----------------------------------------
   // external resume pin synchroniser
   // ----------------------------------------
   always @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end
      else
      begin
         ext_s1_q <= EXT_RESUME_PIN_IN;
         ext_s2_q <= ext_s1_q;
         ext_prev_q <= ext_s2_q;
      end
   end

   assign ext_rise = ext_s2_q & ~ext_prev_q;

   // ----------------------------------------
   // suspend detection
   // ----------------------------------------
   always @*
   begin
      state_d = state_q;
      idle_d = idle_q;
      susp_evt = 1'b0;
      case (state_q)
         ST_ACTIVE:
         begin
            if (!BUS_IDLE_IN)
            begin
               idle_d = 32'h0000_0000;
            end
            else if (idle_q >= SUSP_CYCLES - 1)
            begin
               state_d = ST_SUSP; // [R13]
               susp_evt = 1'b1;
               idle_d = 32'h0000_0000;
            end
            else
            begin
               idle_d = idle_q + 32'h0000_0001;
            end
         end
         ST_SUSP:
         begin
            if (!BUS_IDLE_IN)
            begin
               state_d = ST_ACTIVE;
            end
         end
         default:
         begin
            state_d = ST_ACTIVE;
            idle_d = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         state_q <= ST_ACTIVE;
         idle_q <= 32'h0000_0000;
         mask_q <= `UDAR_MASK_RST; // [R10] [R19]
         stat_q <= `UDAR_STAT_RST; // [R19]
      end
      else
      begin
         state_q <= state_d;
         idle_q <= idle_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
      end
   end

   assign SUSPENDED_OUT = state_q;

   // ----------------------------------------
   // interrupt status
   // ----------------------------------------
   // endpoint bits mirror the endpoint flags, so they clear only when
   // firmware clears the flag in the endpoint's own register
   always @(posedge REF_CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         ep_q <= {NUM_EP{1'b0}};
      end
      else
      begin
         ep_q <= SETUP_RECEIVED_IN | BANK_A_RECEIVED_IN | BANK_B_RECEIVED_IN
            | IN_TRANSFER_DONE_IN | STALL_ACKNOWLEDGED_IN; // [R11] [R12]
      end
   end

   assign bus_evt[`UDAR_EP_MSB:0] = 8'h00;
   assign bus_evt[`UDAR_B_SUSP] = susp_evt; // [R13]
   assign bus_evt[`UDAR_B_RSM] = HOST_RESUME_IN;
   assign bus_evt[`UDAR_B_EXTERNAL_RESUME_IRQ] = ext_rise & (state_q == ST_SUSP);
   assign bus_evt[`UDAR_B_SOF] = FRAME_START_IN; // [R16]
   assign bus_evt[`UDAR_B_BUSRES] = BUS_RESET_DONE_IN; // [R15]
   assign bus_evt[`UDAR_B_WAKE] = HOST_RESUME_IN | BUS_RESET_DONE_IN
      | (ext_rise & (state_q == ST_SUSP));

   // a read clears only the bus bits it returned, so an event landing
   // after the data was sampled survives; a new event beats any clear
   always @*
   begin
      stat_d = stat_q;
      if (rd_now && hit(WB_ADR_IN, `UDAR_OFS_ISTAT))
      begin
         stat_d = stat_d & ~(rdat_q[`UDAR_IRQ_MSB:0] & `UDAR_BUS_CLR);
      end
      if (wr_now && hit(WB_ADR_IN, `UDAR_OFS_ICLR))
      begin
         stat_d = stat_d & ~(wbits[`UDAR_IRQ_MSB:0] & `UDAR_BUS_CLR); // [R17]
      end
      stat_d = stat_d | bus_evt; // [R14]
      stat_d[`UDAR_EP_MSB:0] = ep_q[`UDAR_EP_MSB:0]; // [R6]
   end

   assign IRQ_OUT = |(stat_q & mask_q); // [R18]

endmodule // udar_regs

// ---- src/udar_consts.vh ----
/*
 Constants for the USB device address and interrupt register block:
 register byte offsets, bit positions, reset values, timing figures.
 Assumes inclusion by the single design file of the block.
*/
`ifndef UDAR_CONSTS_VH
`define UDAR_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UDAR_OFS_FADDR 8'h08
`define UDAR_OFS_IEN 8'h10
`define UDAR_OFS_IDIS 8'h14
`define UDAR_OFS_IMASK 8'h18
`define UDAR_OFS_ISTAT 8'h1C
`define UDAR_OFS_ICLR 8'h20

// ----------------------------------------
// function address fields
// ----------------------------------------
`define UDAR_FUNC_ADDR_VALUE_MSB 6
`define UDAR_FEN_BIT 8
`define UDAR_FUNC_ADDR_VALUE_RST 7'h00
`define UDAR_FEN_RST 1'h1

// ----------------------------------------
// interrupt bit positions
// ----------------------------------------
`define UDAR_EP_MSB 7
`define UDAR_B_SUSP 8
`define UDAR_B_RSM 9
`define UDAR_B_EXTERNAL_RESUME_IRQ 10
`define UDAR_B_SOF 11
`define UDAR_B_BUSRES 12
`define UDAR_B_WAKE 13
`define UDAR_IRQ_MSB 13

// ----------------------------------------
// reset values and writable bits
// ----------------------------------------
`define UDAR_MASK_RST 14'h1200
`define UDAR_MASK_WR 14'h2FFF
`define UDAR_STAT_RST 14'h0000
`define UDAR_BUS_CLR 14'h3F00

// ----------------------------------------
// timing
// ----------------------------------------
`define UDAR_CLK_KHZ 10000
`define UDAR_SUSP_TIME_MS 3

`endif

// ---- tb/udar_regs_assertions.sv ----
/* Assertions on the port timing of the address and interrupt block.
 Assumes bind onto udar_regs, with SUSP_CYCLES handed on. */
`timescale 1ns/1ps
`include "udar_consts.vh"
module udar_regs_checker #(parameter SUSP_CYCLES = 16)
(
   input wire REF_CLK_IN, // clock
   input wire RESETN_IN, // reset, low
   input wire WB_CYC_IN, // cycle
   input wire WB_STB_IN, // strobe
   input wire WB_WE_IN, // write
   input wire [7:0] WB_ADR_IN, // address
   input wire WB_ACK_OUT, // ack
   input wire BUS_IDLE_IN, // idle
   input wire BUS_RESET_DONE_IN, // reset done
   input wire [`UDAR_FUNC_ADDR_VALUE_MSB:0] FUNC_ADDR_VALUE_OUT, // address
   input wire FUNC_ENDPOINTS_ON_OUT, // enable
   input wire SUSPENDED_OUT, // suspend
   input wire IRQ_OUT // irq
);
   int idle_cnt_q;
   wire fa_wr = WB_ACK_OUT && WB_WE_IN && WB_ADR_IN == `UDAR_OFS_FADDR;
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   // ----
   // idle run length
   // ----
   always @(posedge REF_CLK_IN or negedge RESETN_IN)
      if (!RESETN_IN)
         idle_cnt_q <= 0;
      else
         idle_cnt_q <= BUS_IDLE_IN ? idle_cnt_q + 1 : 0;
   a_ack_one_cycle: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack longer than one cycle");
   a_ack_follows_req: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
      else $error("request not acked");
   a_ack_needs_req: assert property (!(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT)
      else $error("ack without request");
   a_busres_irq: assert property (BUS_RESET_DONE_IN |=> IRQ_OUT)
      else $error("reset done gave no irq");
   a_reset_quiet: assert property ($rose(RESETN_IN) |->
      !IRQ_OUT && FUNC_ENDPOINTS_ON_OUT && FUNC_ADDR_VALUE_OUT == 7'h00)
      else $error("bad values after reset");
   a_addr_by_write: assert property (
      $changed({FUNC_ENDPOINTS_ON_OUT, FUNC_ADDR_VALUE_OUT}) |-> $past(fa_wr))
      else $error("address changed without write");
   a_suspend_time: assert property (idle_cnt_q == SUSP_CYCLES |-> ##[0:2] SUSPENDED_OUT)
      else $error("no suspend after idle");
   a_suspend_leave: assert property (
      SUSPENDED_OUT && !BUS_IDLE_IN |-> ##[1:2] !SUSPENDED_OUT)
      else $error("suspend kept on activity");
endmodule // udar_regs_checker
bind udar_regs udar_regs_checker #(.SUSP_CYCLES(SUSP_CYCLES)) i_chk (
   .REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN), .WB_CYC_IN(WB_CYC_IN),
   .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
   .WB_ACK_OUT(WB_ACK_OUT), .BUS_IDLE_IN(BUS_IDLE_IN), .BUS_RESET_DONE_IN(BUS_RESET_DONE_IN),
   .FUNC_ADDR_VALUE_OUT(FUNC_ADDR_VALUE_OUT), .FUNC_ENDPOINTS_ON_OUT(FUNC_ENDPOINTS_ON_OUT),
   .SUSPENDED_OUT(SUSPENDED_OUT), .IRQ_OUT(IRQ_OUT));

// ---- tb/udar_host_model.sv ----
/* Host side stand-in: endpoint flags, bus event pulses, idle, wake pin.
 Assumes the bench calls its tasks; lines change after a rising edge. */
`timescale 1ns/1ps
module udar_host_model
(
   input wire clk_in, // clock
   output logic [39:0] flags_out, // five flags by eight endpoints
   output logic [2:0] ev_out, // resume, frame start, reset done
   output logic idle_out, // bus idle level
   output logic ext_out // remote wake pin
);
   initial
   begin
      flags_out = 40'h0;
      ev_out = 3'h0;
      idle_out = 1'b0;
      ext_out = 1'b0;
   end
   // ----
   // one-cycle events, as a token lasts one detect
   // ----
   task automatic pulse(input int k);
      @(posedge clk_in);
      ev_out[k] <= 1'b1;
      @(posedge clk_in);
      ev_out[k] <= 1'b0;
   endtask
   task automatic set_flags(input logic [39:0] v);
      @(posedge clk_in);
      flags_out <= v;
   endtask
   task automatic set_idle(input logic v);
      @(posedge clk_in);
      idle_out <= v;
   endtask
   task automatic ext_rise;
      @(posedge clk_in);
      ext_out <= 1'b1;
   endtask
   task automatic ext_fall;
      @(posedge clk_in);
      ext_out <= 1'b0;
   endtask
endmodule // udar_host_model

// ---- tb/testbench.sv ----
/* Self-checking bench: Wishbone tasks, host model, register tests.
 Assumes udar_regs, its constants header, checker and host model. */
`timescale 1ns/1ps
`include "udar_consts.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0, q;
   wire [31:0] rdat;
   wire [39:0] fl;
   wire [2:0] ev;
   wire [6:0] fa;
   wire ack, idle, ext, func_endpoints_on, susp, irq;
   int n_errors = 0, cmp_count = 0;
   udar_regs #(.SUSP_CYCLES(16)) i_dut (
      .REF_CLK_IN(clk), .RESETN_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .SETUP_RECEIVED_IN(fl[7:0]),
      .BANK_A_RECEIVED_IN(fl[15:8]), .BANK_B_RECEIVED_IN(fl[23:16]),
      .IN_TRANSFER_DONE_IN(fl[31:24]), .STALL_ACKNOWLEDGED_IN(fl[39:32]),
      .BUS_IDLE_IN(idle), .HOST_RESUME_IN(ev[0]), .EXT_RESUME_PIN_IN(ext),
      .FRAME_START_IN(ev[1]), .BUS_RESET_DONE_IN(ev[2]), .FUNC_ADDR_VALUE_OUT(fa),
      .FUNC_ENDPOINTS_ON_OUT(func_endpoints_on), .SUSPENDED_OUT(susp), .IRQ_OUT(irq));
   udar_host_model i_host (.clk_in(clk), .flags_out(fl), .ev_out(ev), .idle_out(idle),
      .ext_out(ext));
   initial
   begin
      forever #50 clk = ~clk;
   end
   // ----
   // closing and bus tasks
   // ----
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         n_errors++;
         give_verdict();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask
   // partial lane write, to see that sel gates each field
   task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      wb(1'b1, a, d, s);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      `CHK("read", e, q)
   endtask
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(`UDAR_OFS_FADDR, 32'h100);
      rd(`UDAR_OFS_IMASK, 32'h1200);
      rd(`UDAR_OFS_ISTAT, 32'h0);
      $display("reset test done");
      wr(`UDAR_OFS_FADDR, 32'h7F);
      @(posedge clk);
      `CHK("pins", 8'h7F, {func_endpoints_on, fa})
      rd(`UDAR_OFS_FADDR, 32'h7F);
      wr(`UDAR_OFS_FADDR, 32'h105);
      rd(`UDAR_OFS_FADDR, 32'h105);
      wrs(`UDAR_OFS_FADDR, 32'h0000_002A, 4'h1);
      rd(`UDAR_OFS_FADDR, 32'h12A);
      wrs(`UDAR_OFS_FADDR, 32'h0000_00D5, 4'h2);
      rd(`UDAR_OFS_FADDR, 32'h02A);
      wr(8'h0C, 32'hFFFF);
      rd(8'h0C, 32'h0);
      $display("address test done");
      wr(`UDAR_OFS_IDIS, 32'hFFFF_FFFF);
      rd(`UDAR_OFS_IMASK, 32'h1000);
      wr(`UDAR_OFS_IEN, 32'h0A05);
      rd(`UDAR_OFS_IMASK, 32'h1A05);
      wr(`UDAR_OFS_IDIS, 32'h1);
      wr(`UDAR_OFS_IEN, 32'h0);
      wr(`UDAR_OFS_IMASK, 32'hFFFF);
      rd(`UDAR_OFS_IMASK, 32'h1A04);
      $display("mask test done");
      i_host.pulse(1);
      @(posedge clk);
      `CHK("irq", 1'b1, irq)
      rd(`UDAR_OFS_ISTAT, 32'h800);
      @(posedge clk);
      `CHK("irq", 1'b0, irq)
      rd(`UDAR_OFS_ISTAT, 32'h0);
      i_host.pulse(0);
      rd(`UDAR_OFS_ISTAT, 32'h2200);
      i_host.pulse(2);
      wr(`UDAR_OFS_ICLR, 32'h1000);
      rd(`UDAR_OFS_ISTAT, 32'h2000);
      for (int j = 0; j < 5; j++)
      begin
         i_host.set_flags(40'h1 << (9 * j + 1));
         // flags are registered once, then copied into status
         repeat (3) @(posedge clk);
         `CHK("irq", (j == 1), irq)
         rd(`UDAR_OFS_ISTAT, 32'h1 << (j + 1));
         rd(`UDAR_OFS_ISTAT, 32'h1 << (j + 1));
         i_host.set_flags(40'h0);
         repeat (2) @(posedge clk);
         rd(`UDAR_OFS_ISTAT, 32'h0);
      end
      $display("event test done");
      i_host.set_idle(1'b1);
      repeat (24) @(posedge clk);
      `CHK("susp", 1'b1, susp)
      i_host.ext_rise();
      repeat (8) @(posedge clk);
      rd(`UDAR_OFS_ISTAT, 32'h2500);
      i_host.set_idle(1'b0);
      repeat (3) @(posedge clk);
      `CHK("susp", 1'b0, susp)
      i_host.ext_fall();
      i_host.ext_rise();
      repeat (8) @(posedge clk);
      rd(`UDAR_OFS_ISTAT, 32'h0);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`UDAR_OFS_FADDR, 32'h100);
      $display("suspend test done");
      give_verdict();
   end
endmodule // testbench
